// >>> hw/pwc_pkg.sv
package pwc_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int          CNT_W    = 14;
  localparam logic [13:0] CNT_RST  = 14'h0000;
  localparam logic [13:0] CNT_ONE  = 14'h0001;
  localparam logic [7:0]  DIV_RST  = 8'h00;
  localparam logic [7:0]  DIV_ONE  = 8'h01;
  localparam logic [3:0]  SYO_RST  = 4'h0;
  localparam logic [3:0]  SYO_ONE  = 4'h1;
  localparam logic [7:0]  TRIP_RST = 8'h00;
  localparam logic [7:0]  TRIP_ONE = 8'h01;
  localparam logic [7:0]  TRIP_SAT = 8'hFF;
  localparam logic [1:0]  PIN_RST  = 2'h0;

  typedef logic [13:0] pwc_cnt_t;

  // ---------------------------------------------------------------
  // period interrupt divide counts, index is the divide setting
  // ---------------------------------------------------------------
  localparam logic [15:0][7:0] IRQ_DIV_TAB = {
    8'hFF, 8'hDF, 8'hBF, 8'h9F, 8'h7F, 8'h5F, 8'h4F, 8'h3F,
    8'h2F, 8'h1F, 8'h0F, 8'h07, 8'h03, 8'h01, 8'h00, 8'h00
  };

  // ---------------------------------------------------------------
  // compensator scaling codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SC_NONE = 3'h0;
  localparam logic [2:0] SC_MUL2 = 3'h1;
  localparam logic [2:0] SC_MUL4 = 3'h2;
  localparam logic [2:0] SC_MUL8 = 3'h3;
  localparam logic [2:0] SC_DIV2 = 3'h4;
  localparam logic [2:0] SC_DIV4 = 3'h5;
  localparam logic [2:0] SC_DIV8 = 3'h6;

  typedef enum logic [1:0] {
    PWC_NORMAL = 2'b00,
    PWC_MULTI  = 2'b01,
    PWC_RESON  = 2'b10,
    PWC_PHASE  = 2'b11
  } pwc_mode_e;

  typedef enum logic [1:0] {
    FR_FREE = 2'b00,
    FR_WAIT = 2'b01,
    FR_STEP = 2'b10
  } pwc_frame_e;

  typedef struct packed {
    pwc_mode_e   mode;
    logic [13:0] period;
    logic [13:0] ev1;
    logic [13:0] ev2_init;
    logic [13:0] ev3;
    logic [13:0] ev4;
    logic [13:0] trig;
    logic [3:0]  irq_div;
    logic        eop_en;
    logic        single_frame;
    logic [2:0]  scale;
    logic        trip_en;
    logic        trip_cont;
    logic [7:0]  trip_max;
    logic [1:0]  cmp_sel;
    logic        fault_en;
    logic [1:0]  comp_sel;
    logic [1:0]  ovr_en;
    logic [1:0]  ovr_val;
    logic        msync_en;
    logic [1:0]  msync_sel;
    logic        rsync_en;
    logic [3:0]  sync_ratio;
    logic        sync_out_en;
  } pwc_cfg_s;

endpackage

// >>> hw/pwc_sync2.sv
module pwc_sync2 #(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule

// >>> hw/pwc_trip.sv
module pwc_trip (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  // control
  input  wire logic       i_en,
  input  wire logic       i_cont,
  input  wire logic [7:0] i_max,
  input  wire logic       i_clr,
  // per-period sample of the limit indication
  input  wire logic       i_sample,
  input  wire logic       i_lim,
  // status
  output logic            o_flag,
  output logic      [7:0] o_count
);

  logic       hit;
  logic [7:0] cnt_inc;
  logic [7:0] cnt_d;
  logic       reached;

  assign hit     = i_en & i_sample & i_lim;
  // saturate so a long run in count-continuous mode never wraps
  assign cnt_inc = (o_count == pwc_pkg::TRIP_SAT) ? o_count : o_count + pwc_pkg::TRIP_ONE;
  assign reached = hit & (cnt_inc >= i_max);
  assign cnt_d   = !i_en                      ? pwc_pkg::TRIP_RST :
                   hit                        ? cnt_inc :
                   (i_sample & !i_cont)       ? pwc_pkg::TRIP_RST :
                   o_count;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_count <= pwc_pkg::TRIP_RST;
      o_flag  <= 1'b0;
    end else begin
      o_count <= cnt_d;
      // a new trip in the clearing cycle keeps the flag set
      o_flag  <= reached | (o_flag & ~i_clr);
    end
  end

endmodule

// >>> hw/pwc_ctrl.sv
// Behaviour
// - period interrupt every divide-count plus one periods, count from 4-bit setting.
// - counter equal to sample trigger raises error converter sampling request.
// - end-of-period enable holds new compensator value until period end.
// - single-frame enable runs one switching frame per step request.
// - compensator value scaled by x2, x4, x8, /2, /4, /8 or none.
// - trip counting samples the limit indication once per period at event two.
// - trip flag set when sampled count reaches the 8-bit maximum.
// - count-continuous 0 clears trip count on any period without indication.
// - count-continuous 1 accumulates indications with no clearing.
// - trip flag goes to the CPU and forces both outputs inactive.
// - limit input chosen from comparators A to D by a select field.
// - each output may be overridden by its own enable and value bit.
// - both modulator pin levels are readable as status bits.
// - fault enable turns outputs off while an external fault is asserted.
// - normal mode forces both outputs off on either fault input.
// - other modes map fault 0 to output A and fault 1 to B.
// - after the fault latch clears, switching resumes at a period start.
// - 2-bit field selects which compensator supplies the control value.
// - resonance mode uses the compensator with this modulator's own index.
// - internal sync slave resets counter on selected master phase trigger.
// - remote sync slave resets counter on the external sync pin pulse.
// - sync output pulses once every ratio-plus-one periods when routed out.
// - base interrupt tick once per switching period from the period value.
module pwc_ctrl #(
  // index of this modulator among the compensators
  parameter logic [1:0] CHAN_IDX = 2'h0
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  // configuration and software strobes
  input  wire pwc_pkg::pwc_cfg_s i_cfg,
  input  wire logic              i_frame_step,
  input  wire logic              i_trip_clr,
  // compensators
  input  wire logic [3:0][13:0]  i_comp_val,
  input  wire logic [3:0]        i_comp_vld,
  // faults, comparators and sync
  input  wire logic [1:0]        i_fault,
  input  wire logic [3:0]        i_cmp_raw,
  input  wire logic [3:0]        i_master_trig,
  input  wire logic              i_sync_pin,
  input  wire logic [1:0]        i_pin_raw,
  // modulator outputs
  output logic                   o_pwm_a,
  output logic                   o_pwm_b,
  // events and status
  output logic                   o_adc_sample_req,
  output logic                   o_period_irq,
  output logic                   o_trip_flag,
  output logic                   o_sync_out,
  output logic      [1:0]        o_pin_level,
  output logic      [13:0]       o_duty
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [6:0] syn;
  logic [3:0] cmp_s;
  logic       sync_s;
  logic [1:0] pin_s;
  logic       sync_prev_q;
  logic       sync_rise;

  pwc_sync2 #(
    .W (7)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_d       ({i_pin_raw, i_sync_pin, i_cmp_raw}),
    .o_q       (syn)
  );

  assign cmp_s     = syn[3:0];
  assign sync_s    = syn[4];
  assign pin_s     = syn[6:5];
  assign sync_rise = sync_s & ~sync_prev_q;

  // ---------------------------------------------------------------
  // frame control and period counter
  // ---------------------------------------------------------------
  pwc_pkg::pwc_frame_e frame_q;
  pwc_pkg::pwc_frame_e frame_d;
  pwc_pkg::pwc_cnt_t   cnt_q;
  pwc_pkg::pwc_cnt_t   cnt_d;
  logic                run;
  logic                per_end;
  logic                msync_hit;
  logic                rsync_hit;
  logic                sync_rst;

  assign run       = (frame_q != pwc_pkg::FR_WAIT);
  assign per_end   = run & (cnt_q >= i_cfg.period);
  assign msync_hit = i_cfg.msync_en & i_master_trig[i_cfg.msync_sel];
  assign rsync_hit = i_cfg.rsync_en & sync_rise;
  assign sync_rst  = msync_hit | rsync_hit;
  // a sync restart is not a period end: no tick, no update
  assign cnt_d     = sync_rst ? pwc_pkg::CNT_RST :
                     !run     ? cnt_q :
                     per_end  ? pwc_pkg::CNT_RST :
                     cnt_q + pwc_pkg::CNT_ONE;

  always_comb begin
    frame_d = frame_q;
    unique case (frame_q)
      pwc_pkg::FR_FREE: begin
        if (i_cfg.single_frame && per_end) begin
          frame_d = pwc_pkg::FR_WAIT;
        end
      end
      pwc_pkg::FR_WAIT: begin
        if (!i_cfg.single_frame) begin
          frame_d = pwc_pkg::FR_FREE;
        end else if (i_frame_step) begin
          frame_d = pwc_pkg::FR_STEP;
        end
      end
      pwc_pkg::FR_STEP: begin
        if (per_end) begin
          frame_d = i_cfg.single_frame ? pwc_pkg::FR_WAIT : pwc_pkg::FR_FREE;
        end
      end
      default: begin
        frame_d = pwc_pkg::FR_FREE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      frame_q     <= pwc_pkg::FR_FREE;
      cnt_q       <= pwc_pkg::CNT_RST;
      sync_prev_q <= 1'b0;
    end else begin
      frame_q     <= frame_d;
      cnt_q       <= cnt_d;
      sync_prev_q <= sync_s;
    end
  end

  // ---------------------------------------------------------------
  // compensator select, scaling and update timing
  // ---------------------------------------------------------------
  logic [1:0]        comp_sel;
  pwc_pkg::pwc_cnt_t comp_raw;
  logic              comp_vld;
  pwc_pkg::pwc_cnt_t comp_scaled;
  pwc_pkg::pwc_cnt_t pend_q;
  logic              pend_vld_q;
  logic              apply;
  logic              smp_hit;

  assign comp_sel = (i_cfg.mode == pwc_pkg::PWC_RESON) ? CHAN_IDX :
                    i_cfg.comp_sel;
  assign comp_raw = i_comp_val[comp_sel];
  assign comp_vld = i_comp_vld[comp_sel];
  // left shifts drop the top bits; gain is the user's to keep in range
  assign comp_scaled = (i_cfg.scale == pwc_pkg::SC_MUL2) ? comp_raw << 1 :
                       (i_cfg.scale == pwc_pkg::SC_MUL4) ? comp_raw << 2 :
                       (i_cfg.scale == pwc_pkg::SC_MUL8) ? comp_raw << 3 :
                       (i_cfg.scale == pwc_pkg::SC_DIV2) ? comp_raw >> 1 :
                       (i_cfg.scale == pwc_pkg::SC_DIV4) ? comp_raw >> 2 :
                       (i_cfg.scale == pwc_pkg::SC_DIV8) ? comp_raw >> 3 :
                       comp_raw;
  // fixed two-cycle latency, or deferred to the period boundary
  assign apply   = pend_vld_q & (~i_cfg.eop_en | per_end);
  assign smp_hit = run & (cnt_q == i_cfg.trig);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pend_q           <= pwc_pkg::CNT_RST;
      pend_vld_q       <= 1'b0;
      o_duty           <= pwc_pkg::CNT_RST;
      o_adc_sample_req <= 1'b0;
    end else begin
      if (comp_vld) begin
        pend_q <= comp_scaled;
      end
      pend_vld_q <= comp_vld | (pend_vld_q & ~apply);
      if (apply) begin
        o_duty <= pend_q;
      end
      o_adc_sample_req <= smp_hit;
    end
  end

  // ---------------------------------------------------------------
  // edge placement
  // ---------------------------------------------------------------
  pwc_pkg::pwc_cnt_t dead23;
  pwc_pkg::pwc_cnt_t width_a;
  pwc_pkg::pwc_cnt_t b_rise;
  pwc_pkg::pwc_cnt_t b_fall;
  logic              a_raw;
  logic              b_raw;
  logic              ev2_hit;

  assign dead23  = i_cfg.ev3 - i_cfg.ev2_init;
  assign width_a = o_duty - i_cfg.ev1;
  assign b_rise  = (i_cfg.mode == pwc_pkg::PWC_NORMAL ||
                    i_cfg.mode == pwc_pkg::PWC_RESON) ? o_duty + dead23 : i_cfg.ev3;
  assign b_fall  = (i_cfg.mode == pwc_pkg::PWC_MULTI) ? i_cfg.ev3 + width_a : i_cfg.ev4;
  assign a_raw   = run & (cnt_q >= i_cfg.ev1) & (cnt_q < o_duty);
  assign b_raw   = run & (cnt_q >= b_rise) & (cnt_q < b_fall);
  assign ev2_hit = run & (cnt_q == o_duty);

  // ---------------------------------------------------------------
  // current-limit trip
  // ---------------------------------------------------------------
  logic [7:0] trip_cnt;

  pwc_trip u_trip (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_en      (i_cfg.trip_en),
    .i_cont    (i_cfg.trip_cont),
    .i_max     (i_cfg.trip_max),
    .i_clr     (i_trip_clr),
    .i_sample  (ev2_hit),
    .i_lim     (cmp_s[i_cfg.cmp_sel]),
    .o_flag    (o_trip_flag),
    .o_count   (trip_cnt)
  );

  // ---------------------------------------------------------------
  // fault gating and output drive
  // ---------------------------------------------------------------
  logic hold_a_q;
  logic hold_b_q;
  logic flt_a;
  logic flt_b;
  logic a_on;
  logic b_on;

  assign flt_a = i_cfg.fault_en & ((i_cfg.mode == pwc_pkg::PWC_NORMAL) ? |i_fault :
                                   i_fault[0]);
  assign flt_b = i_cfg.fault_en & ((i_cfg.mode == pwc_pkg::PWC_NORMAL) ? |i_fault :
                                   i_fault[1]);
  assign a_on  = a_raw & ~flt_a & ~hold_a_q & ~o_trip_flag;
  assign b_on  = b_raw & ~flt_b & ~hold_b_q & ~o_trip_flag;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      hold_a_q    <= 1'b0;
      hold_b_q    <= 1'b0;
      o_pwm_a     <= 1'b0;
      o_pwm_b     <= 1'b0;
      o_pin_level <= pwc_pkg::PIN_RST;
    end else begin
      // hold past the fault so switching restarts on a whole period
      hold_a_q    <= flt_a | (hold_a_q & ~per_end);
      hold_b_q    <= flt_b | (hold_b_q & ~per_end);
      o_pwm_a     <= i_cfg.ovr_en[0] ? i_cfg.ovr_val[0] : a_on;
      o_pwm_b     <= i_cfg.ovr_en[1] ? i_cfg.ovr_val[1] : b_on;
      o_pin_level <= pin_s;
    end
  end

  // ---------------------------------------------------------------
  // period interrupt divider and sync output
  // ---------------------------------------------------------------
  logic [7:0] div_q;
  logic [7:0] div_lim;
  logic       div_wrap;
  logic [3:0] syo_q;
  logic       syo_wrap;

  assign div_lim  = pwc_pkg::IRQ_DIV_TAB[i_cfg.irq_div];
  assign div_wrap = per_end & (div_q >= div_lim);
  assign syo_wrap = per_end & (syo_q >= i_cfg.sync_ratio);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      div_q        <= pwc_pkg::DIV_RST;
      syo_q        <= pwc_pkg::SYO_RST;
      o_period_irq <= 1'b0;
      o_sync_out   <= 1'b0;
    end else begin
      if (per_end) begin
        div_q <= div_wrap ? pwc_pkg::DIV_RST : div_q + pwc_pkg::DIV_ONE;
        syo_q <= syo_wrap ? pwc_pkg::SYO_RST : syo_q + pwc_pkg::SYO_ONE;
      end
      o_period_irq <= div_wrap;
      o_sync_out   <= syo_wrap & i_cfg.sync_out_en;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  property p_irq_div;
    per_end && div_q == div_lim |=> o_period_irq;
  endproperty
  a_irq_div: assert property (p_irq_div) else $error("divided tick missing");

  property p_irq_only_on_end;
    o_period_irq |-> $past(per_end);
  endproperty
  a_irq_only_on_end: assert property (p_irq_only_on_end) else $error("stray tick");

  property p_sample_req;
    smp_hit |=> o_adc_sample_req ##1 !o_adc_sample_req || $past(smp_hit);
  endproperty
  a_sample_req: assert property (p_sample_req) else $error("sample request wrong");

  property p_eop_defer;
    i_cfg.eop_en && pend_vld_q && !per_end |=> $stable(o_duty);
  endproperty
  a_eop_defer: assert property (p_eop_defer) else $error("update inside period");

  property p_frame_wait;
    frame_q == pwc_pkg::FR_WAIT && !sync_rst |=> $stable(cnt_q);
  endproperty
  a_frame_wait: assert property (p_frame_wait) else $error("counter ran in wait");

  property p_trip_off;
    o_trip_flag && !i_cfg.ovr_en[0] && !i_cfg.ovr_en[1] |=> !o_pwm_a && !o_pwm_b;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("output on during trip");

  property p_ovr;
    i_cfg.ovr_en[0] |=> o_pwm_a == $past(i_cfg.ovr_val[0]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override value not driven");

  property p_fault_normal;
    i_cfg.fault_en && i_cfg.mode == pwc_pkg::PWC_NORMAL && i_fault[1]
      && !i_cfg.ovr_en[0] |=> !o_pwm_a;
  endproperty
  a_fault_normal: assert property (p_fault_normal) else $error("fault 1 left A on");

  property p_fault_split;
    i_cfg.fault_en && i_cfg.mode == pwc_pkg::PWC_MULTI && i_fault[0]
      && !i_cfg.ovr_en[0] |=> !o_pwm_a;
  endproperty
  a_fault_split: assert property (p_fault_split) else $error("fault 0 left A on");

  property p_resume;
    $fell(hold_a_q) |-> $past(per_end);
  endproperty
  a_resume: assert property (p_resume) else $error("resume inside period");

  property p_rsync;
    rsync_hit |=> cnt_q == pwc_pkg::CNT_RST;
  endproperty
  a_rsync: assert property (p_rsync) else $error("remote sync ignored");

  property p_trip_disabled;
    !i_cfg.trip_en |=> trip_cnt == pwc_pkg::TRIP_RST;
  endproperty
  a_trip_disabled: assert property (p_trip_disabled) else $error("count kept");

  c_trip: cover property (!o_trip_flag ##1 o_trip_flag);
  c_irq_div: cover property (o_period_irq && div_lim == 8'h2F);
  c_step: cover property (frame_q == pwc_pkg::FR_WAIT ##1 frame_q == pwc_pkg::FR_STEP);
  c_resume: cover property ($fell(hold_b_q));

endmodule

// >>> test/pwc_far.sv
module pwc_far (
  // clock
  input  wire logic             i_sys_clk,
  // bench commands
  input  wire logic [3:0]       i_ld,
  input  wire logic [13:0]      i_val,
  input  wire logic [1:0]       i_flt_set,
  input  wire logic             i_flt_clr,
  // toward the controller
  output logic      [3:0][13:0] o_comp_val,
  output logic      [3:0]       o_comp_vld,
  output logic      [1:0]       o_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0][13:0] val_q;

  initial begin
    val_q      = '0;
    o_comp_vld = 4'h0;
    o_fault    = 2'h0;
  end

  // lanes carry junk outside a strobe, no kinder than a real bus
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_comp_val[k] = o_comp_vld[k] ? val_q[k] : ~val_q[k];
    end
  end

  always @(posedge i_sys_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (i_ld[k]) begin
        val_q[k] <= i_val;
      end
    end
    o_comp_vld <= i_ld;
    // fault stays latched until firmware clears the pending flag
    o_fault <= i_flt_clr ? 2'h0 : (o_fault | i_flt_set);
  end
endmodule

// >>> test/test_pwc_ctrl.sv
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module test_pwc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic              clk = 1'b0;
  logic              rst_b, fstep, tclr, spin, fclr;
  pwc_pkg::pwc_cfg_s cfg;
  logic [3:0]        ld, cmp, mtrig, vld;
  logic [13:0]       val, duty;
  logic [1:0]        fset, praw, flt, plev;
  logic [3:0][13:0]  cval;
  logic              pa, pb, req, irq, flag, sout;
  logic [2:0]        ev;
  int                mismatches = 0;
  int                n_checks = 0;
  int                n, na, nb, nr;

  assign ev = {sout, irq, req};
  always #2.5 clk = ~clk;

  pwc_far far (.i_sys_clk(clk), .i_ld(ld), .i_val(val), .i_flt_set(fset), .i_flt_clr(fclr),
    .o_comp_val(cval), .o_comp_vld(vld), .o_fault(flt));
  pwc_ctrl #(.CHAN_IDX(2'h2)) dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_cfg(cfg),
    .i_frame_step(fstep), .i_trip_clr(tclr), .i_comp_val(cval), .i_comp_vld(vld),
    .i_fault(flt), .i_cmp_raw(cmp), .i_master_trig(mtrig), .i_sync_pin(spin),
    .i_pin_raw(praw), .o_pwm_a(pa), .o_pwm_b(pb), .o_adc_sample_req(req),
    .o_period_irq(irq), .o_trip_flag(flag), .o_sync_out(sout), .o_pin_level(plev),
    .o_duty(duty));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic nxt(input int i, output int t);
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (ev[i] !== 1'b1 && t < 3000);
    if (t >= 3000) `CK(t, 0)
  endtask

  task automatic obs(input int len);
    na = 0;
    nb = 0;
    nr = 0;
    repeat (len) begin
      @(negedge clk);
      na += (pa === 1'b1);
      nb += (pb === 1'b1);
      nr += (req === 1'b1);
    end
  endtask

  task automatic comp(input int k, input logic [13:0] v);
    ld = 4'h1 << k;
    val = v;
    @(negedge clk);
    ld = 4'h0;
    repeat (3) @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_irq;
    int s[5] = '{1, 2, 3, 4, 7};
    int c[5] = '{0, 1, 3, 7, 47};
    for (int k = 0; k < 5; k++) begin
      cfg.irq_div = 4'(s[k]);
      nxt(1, n);
      nxt(1, n);
      `CK(n, 32 * (c[k] + 1))
    end
    // first request lands a few cycles after the tick; time the next one
    nxt(0, n);
    nxt(0, n);
    `CK(n, 32)
  endtask

  task automatic t_scale;
    logic [13:0] e;
    for (int c = 0; c < 7; c++) begin
      cfg.scale = 3'(c);
      comp(0, 14'h0123);
      e = (c == 0) ? 14'h0123 : (c < 4) ? (14'h0123 << c) : (14'h0123 >> (c - 3));
      `CK(duty, e)
    end
    cfg.scale = 3'h0;
    cfg.comp_sel = 2'h1;
    comp(1, 14'h0055);
    `CK(duty, 14'h0055)
    comp(0, 14'h0077);
    `CK(duty, 14'h0055)
    cfg.mode = pwc_pkg::PWC_RESON;
    comp(1, 14'h0011);
    `CK(duty, 14'h0055)
    comp(2, 14'h0033);
    `CK(duty, 14'h0033)
    cfg.mode = pwc_pkg::PWC_NORMAL;
    cfg.comp_sel = 2'h0;
    comp(0, 14'h0010);
  endtask

  task automatic t_eop;
    cfg.eop_en = 1'b1;
    nxt(0, n);
    comp(0, 14'h0008);
    `CK(duty, 14'h0010)
    repeat (30) @(negedge clk);
    `CK(duty, 14'h0008)
    cfg.eop_en = 1'b0;
    comp(0, 14'h0010);
  endtask

  task automatic t_trip;
    cfg.cmp_sel = 2'h2;
    cfg.trip_max = 8'h03;
    nxt(0, n);
    cmp = 4'h4;
    cfg.trip_en = 1'b1;
    // alternate hit and miss, so no run ever gets long enough
    repeat (6) begin
      nxt(0, n);
      cmp[2] = ~cmp[2];
    end
    `CK(flag, 1'b0)
    nxt(0, n);
    nxt(0, n);
    `CK(flag, 1'b0)
    nxt(0, n);
    `CK(flag, 1'b1)
    obs(40);
    `CK(na + nb, 0)
    cfg.trip_en = 1'b0;
    repeat (3) @(negedge clk);
    `CK(flag, 1'b1)
    tclr = 1'b1;
    @(negedge clk);
    tclr = 1'b0;
    @(negedge clk);
    `CK(flag, 1'b0)
    cfg.trip_cont = 1'b1;
    nxt(0, n);
    cfg.trip_en = 1'b1;
    repeat (4) begin
      nxt(0, n);
      cmp[2] = ~cmp[2];
    end
    `CK(flag, 1'b0)
    nxt(0, n);
    `CK(flag, 1'b1)
    cfg.trip_en = 1'b0;
    cmp = 4'h0;
    tclr = 1'b1;
    @(negedge clk);
    tclr = 1'b0;
  endtask

  task automatic t_fault;
    cfg.fault_en = 1'b1;
    nxt(0, n);
    fset = 2'h2;
    @(negedge clk);
    fset = 2'h0;
    obs(40);
    `CK(na + nb, 0)
    nxt(0, n);
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    obs(8);
    `CK(na, 0)
    obs(40);
    `CK(na > 0, 1'b1)
    cfg.mode = pwc_pkg::PWC_MULTI;
    fset = 2'h1;
    @(negedge clk);
    fset = 2'h0;
    obs(40);
    `CK(na, 0)
    `CK(nb > 0, 1'b1)
    // override beats the still-latched fault
    cfg.ovr_en = 2'h3;
    for (int k = 1; k < 3; k++) begin
      cfg.ovr_val = 2'(k);
      repeat (3) @(negedge clk);
      obs(40);
      `CK(na, (k == 1) ? 40 : 0)
      `CK(nb, (k == 2) ? 40 : 0)
    end
    cfg.ovr_en = 2'h0;
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    cfg.mode = pwc_pkg::PWC_NORMAL;
    cfg.fault_en = 1'b0;
  endtask

  task automatic t_sync;
    praw = 2'h2;
    repeat (5) @(negedge clk);
    `CK(plev, 2'h2)
    cfg.msync_en = 1'b1;
    cfg.msync_sel = 2'h3;
    for (int k = 2; k < 4; k++) begin
      nxt(0, n);
      repeat (10) @(negedge clk);
      mtrig = 4'h1 << k;
      @(negedge clk);
      mtrig = 4'h0;
      nxt(0, n);
      `CK(n < 10, k == 3)
    end
    cfg.msync_en = 1'b0;
    cfg.rsync_en = 1'b1;
    nxt(0, n);
    repeat (10) @(negedge clk);
    spin = 1'b1;
    nxt(0, n);
    `CK(n < 14, 1'b1)
    spin = 1'b0;
    cfg.rsync_en = 1'b0;
    cfg.sync_ratio = 4'h2;
    cfg.sync_out_en = 1'b1;
    nxt(2, n);
    nxt(2, n);
    `CK(n, 96)
  endtask

  task automatic t_frame;
    cfg.single_frame = 1'b1;
    repeat (70) @(negedge clk);
    obs(70);
    `CK(nr, 0)
    fstep = 1'b1;
    @(negedge clk);
    fstep = 1'b0;
    obs(70);
    `CK(nr, 1)
    cfg.single_frame = 1'b0;
  endtask

  task automatic summarize;
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {rst_b, fstep, tclr, spin, fclr, ld, cmp, mtrig, val, fset, praw} = '0;
    cfg = '0;
    cfg.period = 14'h001F;
    cfg.ev2_init = 14'h0010;
    cfg.ev3 = 14'h0012;
    cfg.ev4 = 14'h001C;
    cfg.trig = 14'h0004;
    cfg.irq_div = 4'h1;
    repeat (2) @(negedge clk);
    `CK({pa, pb, req, irq, flag, sout}, 6'h00)
    `CK(duty, 14'h0000)
    rst_b = 1'b1;
    @(negedge clk);
    comp(0, 14'h0010);
    t_irq();
    t_scale();
    t_eop();
    t_trip();
    t_fault();
    t_sync();
    t_frame();
    summarize();
  end

  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
